// ### tic_top.sv
/*
  Time interval counter: APB register slave, real-time counters, control
  register and interval timeout with wake request.
  Assumes an APB master on pclk, a synchronous warm reset request from the
  system reset logic, and an interrupt controller that supplies the enable.
*/
// The implementer's own choices: the register offsets and the APB slave port.
// How it works
// - Counters run from crystal-rate enables, independent of any core clock.
// - Timeouts span one 1/128 s tick up to 256 hours (interval value zero).
// - Hardware counts only sub-seconds, seconds, minutes, hours; software counts days.
// - Time registers accept writes only while time clock enable is low.
// - Warm reset keeps time clock enable and time registers when enable set.
// - Power-on reset, or any reset with enable clear, zeroes time registers.
// - Two-bit select picks tick, second, minute or hour rollover for interval.
// - Counter equal to interval value sets flag; only software or a reset clears it.
// - Flag with interrupt enabled in power-down wakes part to vector 0053H.
// - Single-shot timeout clears interval enable; otherwise counting repeats.
// - Clearing interval enable disables and clears the interval counter.
// - Clearing time clock enable stops the clock, clears prescaler and time.
// - Control bits: select 5:4, single 3, flag 2, enable 1, clock 0.
// - Sub-second counter counts 0 to 127 each 1/128 s, then carries.
// - Seconds and minutes count 0 to 59, then carry upward.
// - Hours count 0 to 23 then wrap to zero.
// - Interval value register holds 0 to 255, zero after any reset.
`timescale 1ns/1ps
`include "tic_defs.svh"
module tic_top
  import tic_pkg::*;
#(
  parameter int PCLK_HZ = `TIC_PCLK_HZ,
  parameter int XTAL_HZ = `TIC_XTAL_HZ
) (
  input wire logic pclk, // system clock, 25 MHz
  input wire logic presetn, // power-on reset, active low
  input wire logic warm_reset, // hardware or watchdog reset, synchronous
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic irq_enable, // interval interrupt enable from controller
  input wire logic power_down, // part is in power-down
  output logic interval_irq, // interval interrupt request
  output logic wake_req, // wake from power-down
  output logic [15:0] wake_vector // service entry for wake
);
  tic_tick_if tb ();

  logic [7:0] ctrl;
  tic_byte_t interval_value;
  tic_byte_t sub_second_tick_count;
  tic_byte_t one_hz_count;
  tic_byte_t minute_count;
  tic_byte_t hour_count;
  tic_byte_t interval_count;
  logic interval_match;
  logic time_clock_enable_d;
  logic time_clear;

  logic time_clock_enable;
  logic interval_enable;
  logic interval_match_flag;
  logic single_shot_select;
  tic_tbsel_t tbsel;

  logic apb_setup;
  logic apb_write;
  logic [7:0] acc_idx;
  logic idx_ok;
  logic [7:0] wbyte;
  logic [7:0] next_ctrl;
  logic [31:0] next_prdata;
  logic time_clock_enable_fall;

  // Register decode helper, used for write and read paths
  function automatic logic is_reg(input logic [11:0] addr, input logic [7:0] idx);
    is_reg = (addr == {2'b00, idx, 2'b00});
  endfunction : is_reg

  // Carry step shared by the time counters; >= also wraps a stray value
  function automatic tic_byte_t time_step(input tic_byte_t v, input tic_byte_t max);
    time_step = (v >= max) ? 8'h00 : v + 8'h01;
  endfunction : time_step

  // Out-of-range loads pinned to the limit so the carry chain stays sane
  function automatic tic_byte_t time_clamp(input tic_byte_t v, input tic_byte_t max);
    time_clamp = (v > max) ? max : v;
  endfunction : time_clamp

  assign time_clock_enable = ctrl[`TIC_CTRL_TIME_CLOCK_ENABLE];
  assign interval_enable = ctrl[`TIC_CTRL_INTERVAL_ENABLE];
  assign interval_match_flag = ctrl[`TIC_CTRL_FLAG];
  assign single_shot_select = ctrl[`TIC_CTRL_SINGLE];
  assign tbsel = tic_tbsel_t'(ctrl[`TIC_CTRL_TBSEL_HI:`TIC_CTRL_TBSEL_LO]);

  // Zero wait states; the error flag marks unmapped words
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && pstrb[0];
  assign acc_idx = paddr[9:2];
  assign idx_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                  (acc_idx >= `TIC_IDX_CTRL) && (acc_idx <= `TIC_IDX_INTERVAL_VALUE);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !idx_ok;
  assign wbyte = pwdata[7:0];

  // One select per register word, index order from control upward
  localparam int NREG = 6;
  localparam int H_CTRL = 0;
  localparam int H_SUB = 1;
  localparam int H_SEC = 2;
  localparam int H_MIN = 3;
  localparam int H_HOUR = 4;
  localparam int H_IVAL = 5;
  logic [NREG-1:0] hit;
  logic [NREG-1:0] wr_hit;
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_hit
      assign hit[gi] = is_reg(paddr, 8'(`TIC_IDX_CTRL + gi));
    end
  endgenerate
  // Writes decoded once, shared by every register
  assign wr_hit = hit & {NREG{apb_write}};

  tic_prescaler #(
    .PCLK_HZ(PCLK_HZ),
    .XTAL_HZ(XTAL_HZ)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tb(tb)
  );

  tic_interval #(
    .WIDTH(8)
  ) u_interval (
    .pclk(pclk),
    .presetn(presetn),
    .tb(tb),
    .tbsel(tbsel),
    .enable(interval_enable),
    .limit(interval_value),
    .count(interval_count),
    .match(interval_match)
  );

  assign tb.run = time_clock_enable;
  assign tb.roll_sub = tb.tick_128 && (sub_second_tick_count == `TIC_SUBSEC_MAX);
  assign tb.roll_sec = tb.roll_sub && (one_hz_count == `TIC_SEC_MAX);
  assign tb.roll_min = tb.roll_sec && (minute_count == `TIC_MIN_MAX);

  // Next control value; the timeout is applied after the write so a set wins
  always_comb begin
    next_ctrl = ctrl;
    if (warm_reset) begin
      // Warm reset spares only a running clock enable
      next_ctrl = `TIC_CTRL_RESET;
      next_ctrl[`TIC_CTRL_TIME_CLOCK_ENABLE] = ctrl[`TIC_CTRL_TIME_CLOCK_ENABLE];
    end else begin
      if (wr_hit[H_CTRL]) begin
        next_ctrl[`TIC_CTRL_RES6:`TIC_CTRL_SINGLE] = wbyte[`TIC_CTRL_RES6:`TIC_CTRL_SINGLE];
        next_ctrl[`TIC_CTRL_INTERVAL_ENABLE] = wbyte[`TIC_CTRL_INTERVAL_ENABLE];
        next_ctrl[`TIC_CTRL_TIME_CLOCK_ENABLE] = wbyte[`TIC_CTRL_TIME_CLOCK_ENABLE];
        // Writing one to the flag leaves it; zero clears it
        next_ctrl[`TIC_CTRL_FLAG] = interval_match_flag & wbyte[`TIC_CTRL_FLAG];
      end
      if (interval_match) begin
        next_ctrl[`TIC_CTRL_FLAG] = 1'b1;
        if (single_shot_select) begin
          next_ctrl[`TIC_CTRL_INTERVAL_ENABLE] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `TIC_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Falling clock enable, seen one cycle late so writes while low still land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_clock_enable_d <= 1'b0;
    end else begin
      time_clock_enable_d <= time_clock_enable;
    end
  end

  // Power-on clears through presetn; this covers a stop and a warm reset with clock enable low
  assign time_clock_enable_fall = time_clock_enable_d && !time_clock_enable;
  assign time_clear = time_clock_enable_fall || (warm_reset && !time_clock_enable);

  // Interval value: plain byte, cleared by every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_value <= `TIC_INTERVAL_VALUE_RESET;
    end else if (warm_reset) begin
      interval_value <= `TIC_INTERVAL_VALUE_RESET;
    end else if (wr_hit[H_IVAL]) begin
      interval_value <= wbyte;
    end
  end

  // Sub-second counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_second_tick_count <= `TIC_TIME_RESET;
    end else if (time_clear) begin
      sub_second_tick_count <= `TIC_TIME_RESET;
    end else if (!time_clock_enable) begin
      if (wr_hit[H_SUB]) begin
        sub_second_tick_count <= wbyte & `TIC_SUBSEC_MAX;
      end
    end else if (tb.tick_128) begin
      sub_second_tick_count <= time_step(sub_second_tick_count, `TIC_SUBSEC_MAX);
    end
  end

  // Seconds counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_hz_count <= `TIC_TIME_RESET;
    end else if (time_clear) begin
      one_hz_count <= `TIC_TIME_RESET;
    end else if (!time_clock_enable) begin
      if (wr_hit[H_SEC]) begin
        one_hz_count <= time_clamp(wbyte, `TIC_SEC_MAX);
      end
    end else if (tb.roll_sub) begin
      one_hz_count <= time_step(one_hz_count, `TIC_SEC_MAX);
    end
  end

  // Minutes counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      minute_count <= `TIC_TIME_RESET;
    end else if (time_clear) begin
      minute_count <= `TIC_TIME_RESET;
    end else if (!time_clock_enable) begin
      if (wr_hit[H_MIN]) begin
        minute_count <= time_clamp(wbyte, `TIC_MIN_MAX);
      end
    end else if (tb.roll_sec) begin
      minute_count <= time_step(minute_count, `TIC_MIN_MAX);
    end
  end

  // Hours counter; no day count in hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hour_count <= `TIC_TIME_RESET;
    end else if (time_clear) begin
      hour_count <= `TIC_TIME_RESET;
    end else if (!time_clock_enable) begin
      if (wr_hit[H_HOUR]) begin
        hour_count <= time_clamp(wbyte, `TIC_HOUR_MAX);
      end
    end else if (tb.roll_min) begin
      hour_count <= time_step(hour_count, `TIC_HOUR_MAX);
    end
  end

  // Read mux; control bit 7 is reserved and reads zero
  always_comb begin
    next_prdata = 32'h00000000;
    unique case (1'b1)
      hit[H_CTRL]: next_prdata[6:0] = ctrl[6:0];
      hit[H_SUB]: next_prdata[7:0] = sub_second_tick_count;
      hit[H_SEC]: next_prdata[7:0] = one_hz_count;
      hit[H_MIN]: next_prdata[7:0] = minute_count;
      hit[H_HOUR]: next_prdata[7:0] = hour_count;
      hit[H_IVAL]: next_prdata[7:0] = interval_value;
      default: next_prdata = 32'h00000000;
    endcase
  end

  // Read data captured in the setup cycle; one cycle old at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Interrupt enable and power-down state belong to the system
  assign interval_irq = interval_match_flag && irq_enable;
  assign wake_req = interval_match_flag && irq_enable && power_down;
  assign wake_vector = `TIC_WAKE_VECTOR;
endmodule : tic_top

// ### tic_defs.svh
/*
  Constants of the time interval counter: register indices, field positions,
  reset values, counter limits and timing figures.
  Assumes inclusion by bare name from every file that needs a number.
*/
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH

// Clock rates
`define TIC_PCLK_HZ 25000000
`define TIC_XTAL_HZ 32768

// Register indices; byte address is four times the index
`define TIC_IDX_CTRL 8'hA1
`define TIC_IDX_SUBSEC 8'hA2
`define TIC_IDX_SEC 8'hA3
`define TIC_IDX_MIN 8'hA4
`define TIC_IDX_HOUR 8'hA5
`define TIC_IDX_INTERVAL_VALUE 8'hA6

// Control register field positions
`define TIC_CTRL_TIME_CLOCK_ENABLE 0
`define TIC_CTRL_INTERVAL_ENABLE 1
`define TIC_CTRL_FLAG 2
`define TIC_CTRL_SINGLE 3
`define TIC_CTRL_TBSEL_LO 4
`define TIC_CTRL_TBSEL_HI 5
`define TIC_CTRL_RES6 6

// Reset values
`define TIC_CTRL_RESET 8'h00
`define TIC_INTERVAL_VALUE_RESET 8'h00
`define TIC_TIME_RESET 8'h00

// Time counter limits
`define TIC_SUBSEC_MAX 8'h7F
`define TIC_SEC_MAX 8'h3B
`define TIC_MIN_MAX 8'h3B
`define TIC_HOUR_MAX 8'h17

// Interval service entry address reported with a wake request
`define TIC_WAKE_VECTOR 16'h0053

`endif

// ### tic_pkg.sv
/*
  Types shared by the time interval counter modules.
  Assumes nothing beyond the compile order.
*/
package tic_pkg;

  typedef enum logic [1:0] {
    TIC_TB_TICK = 2'b00,
    TIC_TB_SEC = 2'b01,
    TIC_TB_MIN = 2'b10,
    TIC_TB_HOUR = 2'b11
  } tic_tbsel_t;

  typedef logic [7:0] tic_byte_t;

endpackage : tic_pkg

// ### tic_tick_if.sv
/*
  Timebase strobes passed between the prescaler, the time counters and
  the interval counter.
  Assumes the tick and rollover members are one-cycle pulses on pclk; run is a level.
*/
`timescale 1ns/1ps
interface tic_tick_if;
  logic run;
  logic tick_128;
  logic roll_sub;
  logic roll_sec;
  logic roll_min;

  modport prescaler (input run, output tick_128);
  modport timebase (output run, input tick_128, output roll_sub, output roll_sec, output roll_min);
  modport interval (input tick_128, input roll_sub, input roll_sec, input roll_min);
endinterface : tic_tick_if

// ### tic_prescaler.sv
/*
  Crystal-rate enable and 8-bit prescaler giving the 1/128 s tick.
  Assumes pclk is the always-on clock and run is the time clock enable.
*/
`timescale 1ns/1ps
`include "tic_defs.svh"
module tic_prescaler
  import tic_pkg::*;
#(
  parameter int PCLK_HZ = `TIC_PCLK_HZ,
  parameter int XTAL_HZ = `TIC_XTAL_HZ
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // power-on reset, active low
  tic_tick_if.prescaler tb // tick strobes
);
  localparam logic [25:0] PCLK_W = 26'(PCLK_HZ);
  localparam logic [25:0] XTAL_W = 26'(XTAL_HZ);

  logic [25:0] acc;
  logic [25:0] next_acc;
  logic xtal_en;
  logic [7:0] prescale;

  // Fractional divider: crystal edges keep running even when gated
  always_comb begin
    next_acc = acc + XTAL_W;
    xtal_en = 1'b0;
    if (next_acc >= PCLK_W) begin
      next_acc = next_acc - PCLK_W;
      xtal_en = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // Cleared while gated off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 8'h00;
    end else if (!tb.run) begin
      prescale <= 8'h00;
    end else if (xtal_en) begin
      prescale <= prescale + 8'h01;
    end
  end

  assign tb.tick_128 = tb.run && xtal_en && (prescale == 8'hFF);
endmodule : tic_prescaler

// ### tic_interval.sv
/*
  8-bit interval counter clocked by the selected timebase rollover.
  Assumes the strobes of the tick interface are single-cycle pulses.
*/
`timescale 1ns/1ps
`include "tic_defs.svh"
module tic_interval
  import tic_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // power-on reset, active low
  tic_tick_if.interval tb, // timebase strobes
  input wire tic_tbsel_t tbsel, // timebase select
  input wire logic enable, // interval enable
  input wire logic [WIDTH-1:0] limit, // programmed interval
  output logic [WIDTH-1:0] count, // current count
  output logic match // one-cycle timeout pulse
);
  logic step;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    unique case (tbsel)
      TIC_TB_TICK: step = tb.tick_128;
      TIC_TB_SEC: step = tb.roll_sub;
      TIC_TB_MIN: step = tb.roll_sec;
      TIC_TB_HOUR: step = tb.roll_min;
    endcase
  end

  assign next_count = count + WIDTH'(1);
  assign match = enable && step && (next_count == limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (!enable) begin
      count <= '0;
    end else if (match) begin
      count <= '0;
    end else if (step) begin
      count <= next_count;
    end
  end
endmodule : tic_interval

// ### tic_checker.sv
/* Port checker of the time interval counter.
   Assumes binding to tic_top and a single pclk domain. */
`timescale 1ns/1ps
module tic_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic warm_reset, // warm reset
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // write
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic irq_enable, // interrupt enable
  input wire logic power_down, // power-down
  input wire logic interval_irq, // interrupt
  input wire logic wake_req, // wake
  input wire logic [15:0] wake_vector // vector
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mapped;
  logic ctrl_wr;
  assign acc = psel && penable;
  assign mapped = paddr >= 12'h284 && paddr <= 12'h298 && paddr[1:0] == 2'h0;
  assign ctrl_wr = acc && pwrite && paddr == 12'h284;
  a_ready_zero_wait: assert property (pready == acc)
    else $error("pready not tied to access phase");
  a_unmapped_error: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_read_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_ctrl_bit_seven: assert property (acc && !pwrite && paddr == 12'h284 |-> !prdata[7])
    else $error("control bit 7 reads one");
  a_flag_sticky: assert property (interval_irq && !ctrl_wr && !warm_reset ##1 irq_enable |-> interval_irq)
    else $error("flag cleared without software");
  a_irq_masked: assert property (!irq_enable |-> !interval_irq)
    else $error("interrupt raised while disabled");
  a_wake_gate: assert property (wake_req == (interval_irq && power_down))
    else $error("wake request not flag in power-down");
  a_wake_vector: assert property (wake_vector == 16'h0053)
    else $error("wake vector wrong");
  c_irq_rise: cover property ($rose(interval_irq));
  c_wake: cover property (wake_req);
  c_unmapped: cover property (acc && !mapped);
endmodule : tic_checker

bind tic_top tic_checker u_chk (.pclk, .presetn, .warm_reset, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .irq_enable, .power_down, .interval_irq, .wake_req, .wake_vector);

// ### tb_top.sv
/* Self-checking bench of tic_top over APB.
   Assumes crystal rate equal to pclk, so one 1/128 s tick is 256 cycles. */
`timescale 1ns/1ps
`include "tic_defs.svh"
module tb_top;
  import tic_pkg::*;
  localparam logic [11:0] A_CTRL = {2'h0, `TIC_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_IVAL = {2'h0, `TIC_IDX_INTERVAL_VALUE, 2'h0};
  localparam logic [11:0] A_SEC = {2'h0, `TIC_IDX_SEC, 2'h0};
  localparam logic [11:0] A_HOUR = {2'h0, `TIC_IDX_HOUR, 2'h0};
  localparam logic [11:0] A_T [4] = '{{2'h0, `TIC_IDX_SUBSEC, 2'h0}, A_SEC, {2'h0, `TIC_IDX_MIN, 2'h0}, A_HOUR};
  localparam logic [31:0] KEEP = 32'h05201000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic warm_reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic irq_enable = 1'b0;
  logic power_down = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, interval_irq, wake_req;
  logic [15:0] wake_vector;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int t1;
  always #20 pclk = ~pclk;
  // Crystal enable every cycle keeps the time scenarios short
  tic_top #(.PCLK_HZ(25000000), .XTAL_HZ(25000000)) DUT (.pclk, .presetn, .warm_reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq_enable, .power_down, .interval_irq,
    .wake_req, .wake_vector);
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH %s exp %0h got %0h", n, x, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rc(input string n, input logic [11:0] a, input logic [7:0] x);
    xfer(1'b0, a, 8'h00);
    chk(n, {24'h0, x}, q);
  endtask : rc
  task automatic ld(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, A_T[i], v[8*i+:8]);
      rc("time", A_T[i], v[8*i+:8]);
    end
  endtask : ld
  task automatic wflag(input int lim);
    int i = 0;
    while (interval_irq !== 1'b1 && i < lim) begin
      @(negedge pclk);
      i++;
    end
    chk("irq", 32'h1, {31'h0, interval_irq});
  endtask : wflag
  task automatic wrst;
    @(posedge pclk);
    warm_reset <= 1'b1;
    @(posedge pclk);
    warm_reset <= 1'b0;
  endtask : wrst
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl", A_CTRL, 8'h00);
    rc("ival", A_IVAL, 8'h00);
    xfer(1'b0, 12'h2A0, 8'h00);
    chk("err", 32'h1, {31'h0, e});
    xfer(1'b1, A_CTRL, 8'hFC);
    rc("ctrl", A_CTRL, 8'h78);
    xfer(1'b1, A_IVAL, 8'hFF);
    rc("ival", A_IVAL, 8'hFF);
    xfer(1'b1, A_CTRL, 8'h40);
    ld(32'h173B3B7F);
    xfer(1'b1, A_CTRL, 8'h41);
    xfer(1'b1, A_SEC, 8'h05);
    repeat (300) @(posedge pclk);
    for (int i = 1; i < 4; i++) begin
      rc("wrap", A_T[i], 8'h00);
    end
    xfer(1'b0, A_T[0], 8'h00);
    t1 = q;
    // Read setups exactly 256 cycles apart
    repeat (253) @(posedge pclk);
    rc("sub", A_T[0], t1[7:0] + 8'h01);
    xfer(1'b1, A_CTRL, 8'h40);
    rc("sub", A_T[0], 8'h00);
    ld(KEEP);
    xfer(1'b1, A_IVAL, 8'h05);
    xfer(1'b1, A_CTRL, 8'h41);
    wrst();
    rc("ctrl", A_CTRL, 8'h01);
    rc("ival", A_IVAL, 8'h00);
    for (int i = 1; i < 4; i++) begin
      rc("keep", A_T[i], KEEP[8*i+:8]);
    end
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl", A_CTRL, 8'h00);
    rc("hour", A_HOUR, 8'h00);
    xfer(1'b1, A_HOUR, 8'h03);
    wrst();
    rc("hour", A_HOUR, 8'h00);
    irq_enable <= 1'b1;
    xfer(1'b1, A_IVAL, 8'h03);
    xfer(1'b1, A_CTRL, 8'h43);
    wflag(1000);
    t1 = cyc;
    xfer(1'b1, A_CTRL, 8'h43);
    @(negedge pclk);
    chk("clear", 32'h0, {31'h0, interval_irq});
    wflag(1000);
    chk("period", 32'd768, cyc - t1);
    @(posedge pclk);
    irq_enable <= 1'b0;
    @(negedge pclk);
    chk("masked", 32'h0, {31'h0, interval_irq});
    rc("flag", A_CTRL, 8'h47);
    irq_enable <= 1'b1;
    power_down <= 1'b1;
    @(negedge pclk);
    chk("wake", 32'h1, {31'h0, wake_req});
    chk("vec", `TIC_WAKE_VECTOR, {16'h0, wake_vector});
    @(posedge pclk);
    power_down <= 1'b0;
    xfer(1'b1, A_CTRL, 8'h40);
    xfer(1'b1, A_IVAL, 8'h02);
    xfer(1'b1, A_CTRL, 8'h4B);
    wflag(700);
    rc("single", A_CTRL, 8'h4D);
    // Second, minute and hour selects each see their rollover on the second tick only
    for (int k = 1; k < 4; k++) begin
      xfer(1'b1, A_CTRL, 8'h40);
      ld({8'h00, (k > 2) ? 8'h3B : 8'h00, (k > 1) ? 8'h3B : 8'h00, 8'h7E});
      xfer(1'b1, A_IVAL, 8'h01);
      xfer(1'b1, A_CTRL, 8'h43 | 8'(k << 4));
      repeat (300) @(negedge pclk);
      chk("early", 32'h0, {31'h0, interval_irq});
      wflag(400);
    end
    report_and_stop();
  end
endmodule : tb_top
